//--- bench/eqc_master_model.sv
// Two-wire bus master model that writes to the equalizer slave
`default_nettype none

module eqc_master_model (
    output var logic scl_o,    // Bus clock, high when released
    output var logic sda_oe_o, // High while pulling the data line low
    input  wire logic sda_i    // Resolved data line level
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quarter of a 125 ns bit period
    localparam real QTR = 31.25;
    // Extra low time a test may set to act as a slow master
    real extra_low = 0.0;

    // Lines released while idle; SCL stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // Start, also usable as a repeated start with SCL low
    task automatic start_cond();
        #QTR;
        sda_oe_o = 1'b0;
        #QTR;
        scl_o = 1'b1;
        #QTR;
        sda_oe_o = 1'b1;
        #QTR;
        scl_o = 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop_cond();
        #QTR;
        sda_oe_o = 1'b1;
        #QTR;
        scl_o = 1'b1;
        #QTR;
        sda_oe_o = 1'b0;
        #QTR;
    endtask

    // Top n bits of b, MSB first, data moved only while SCL is low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            #(QTR + extra_low);
            sda_oe_o = ~b[i];
            #QTR;
            scl_o = 1'b1;
            #(2.0 * QTR);
            scl_o = 1'b0;
        end
    endtask

    // Whole byte, then the ninth pulse with the line released
    task automatic send_byte(input logic [7:0] b, output logic ack);
        send_bits(b, 8);
        #QTR;
        sda_oe_o = 1'b0;
        #QTR;
        scl_o = 1'b1;
        #1.0;
        ack = ~sda_i;
        #(2.0 * QTR - 2.0);
        ack = ack & ~sda_i;
        #1.0;
        scl_o = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- bench/tb_eqc_i2c_slave.sv
// Self-checking bench of the equalizer two-wire control slave
`default_nettype none

module tb_eqc_i2c_slave import eqc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk_i    = 1'b0;
    logic       sys_rst_i    = 1'b1;
    logic       addr_strap_i = 1'b1;
    logic       scl;
    logic       mst_oe;
    logic       slv_sda;
    logic       slv_oe;
    logic       busy;
    logic       sda_line;
    eqc_step_t  fine;
    eqc_step_t  coarse;
    logic [3:0] cut;
    eqc_gains_t gain;
    logic [2:0] e_fine       = 3'h6;
    logic [2:0] e_coarse     = 3'h5;
    logic [3:0] e_cut        = 4'hf;
    logic [2:0] e_gain [4]   = '{default: 3'h6};
    int         n_errors     = 0;
    int         n_compared   = 0;

    // 250 MHz system clock
    always #2 sys_clk_i = ~sys_clk_i;

    // Open-drain data line with pull-up
    assign sda_line = !(mst_oe || (slv_oe && !slv_sda));

    eqc_master_model eqc_master_model_i (
        .scl_o    (scl),
        .sda_oe_o (mst_oe),
        .sda_i    (sda_line)
    );

    eqc_i2c_slave eqc_i2c_slave_i (
        .sys_clk_i            (sys_clk_i),
        .sys_rst_i            (sys_rst_i),
        .scl_i                (scl),
        .sda_i                (sda_line),
        .sda_o                (slv_sda),
        .sda_oe_o             (slv_oe),
        .addr_strap_i         (addr_strap_i),
        .busy_o               (busy),
        .fine_attenuation_o   (fine),
        .coarse_attenuation_o (coarse),
        .cut_boost_select_o   (cut),
        .band_gain_o          (gain)
    );

    // Compares one value and counts
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // Expected settings after one accepted data byte
    function automatic void model_byte(input eqc_byte_t b);
        if (!b[7]) begin
            e_fine = b[2:0];
            e_coarse = b[5:3];
        end else if (b[6:4] >= 3'h1 && b[6:4] <= 3'h4) begin
            e_cut[b[6:4] - 3'h1] = b[3];
            e_gain[b[6:4] - 3'h1] = b[2:0];
        end
    endfunction

    // All setting outputs against the expected state
    task automatic chk_all();
        chk(12'(fine), 12'(e_fine), "fine");
        chk(12'(coarse), 12'(e_coarse), "coarse");
        chk(12'(cut), 12'(e_cut), "cut");
        chk(gain, {e_gain[3], e_gain[2], e_gain[1], e_gain[0]}, "gain");
    endtask

    // Whole write transfer: start, address, data bytes, stop
    task automatic xfer(input eqc_byte_t adr, input eqc_byte_t q[$],
                        input logic acc);
        logic ack;
        eqc_master_model_i.start_cond();
        eqc_master_model_i.send_byte(adr, ack);
        chk(12'(ack), 12'(acc), "address ack");
        chk(12'(busy), 12'(acc), "busy");
        foreach (q[i]) begin
            eqc_master_model_i.send_byte(q[i], ack);
            chk(12'(ack), 12'(acc), "data ack");
            if (acc) begin
                model_byte(q[i]);
            end
            chk_all();
        end
        eqc_master_model_i.stop_cond();
        repeat (8) @(negedge sys_clk_i);
        chk(12'(busy), 12'h0, "busy after stop");
        chk(12'(slv_oe), 12'h0, "released after stop");
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence of tests
    initial begin
        eqc_byte_t q[$];
        eqc_byte_t bad[4];
        logic      ack;
        bad = '{8'h84, 8'h87, 8'h06, 8'h96};
        repeat (3) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        chk_all();
        chk(12'(slv_oe), 12'h0, "idle drive");
        $display("test reset done");
        xfer(8'h86, '{8'h6b, 8'h00, 8'h2e}, 1'b1);
        $display("test volume done");
        for (int b = 1; b <= 4; b++) begin
            q.push_back({1'b1, 3'(b), 1'(b % 2), 3'(b + 2)});
        end
        for (int m = 0; m < 8; m++) begin
            q.push_back({4'h9 + 4'(m % 4), 1'(m % 2), 3'(m)});
        end
        xfer(8'h86, q, 1'b1);
        $display("test bands done");
        xfer(8'h86, '{8'h8f, 8'hd5, 8'he0, 8'hf7}, 1'b1);
        $display("test unused bands done");
        foreach (bad[i]) begin
            xfer(bad[i], '{8'h12}, 1'b0);
        end
        $display("test foreign address done");
        @(negedge sys_clk_i);
        addr_strap_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        xfer(8'h84, '{8'h12}, 1'b1);
        xfer(8'h86, '{8'h09}, 1'b0);
        $display("test strap done");
        eqc_master_model_i.start_cond();
        eqc_master_model_i.send_byte(8'h84, ack);
        eqc_master_model_i.send_bits(8'h00, 4);
        eqc_master_model_i.start_cond();
        eqc_master_model_i.send_byte(8'h84, ack);
        chk(12'(ack), 12'h1, "repeated start ack");
        chk_all();
        eqc_master_model_i.send_byte(8'h1b, ack);
        model_byte(8'h1b);
        eqc_master_model_i.stop_cond();
        chk_all();
        $display("test partial byte done");
        eqc_master_model_i.extra_low = 400.0;
        xfer(8'h84, '{8'h2d}, 1'b1);
        eqc_master_model_i.extra_low = 0.0;
        $display("test slow master done");
        @(negedge sys_clk_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        e_fine = 3'h6;
        e_coarse = 3'h5;
        e_cut = 4'hf;
        e_gain = '{default: 3'h6};
        repeat (5) @(negedge sys_clk_i);
        chk_all();
        chk(12'(busy), 12'h0, "busy after reset");
        $display("test second reset done");
        end_sim();
    end

    // Cuts a hung run short
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        end_sim();
    end
endmodule

`default_nettype wire

//--- pkg/eqc_pkg.sv
// Types shared by the equalizer control slave
`default_nettype none

package eqc_pkg;

    // Bus protocol states
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_data,
        st_data_ack,
        st_ignore
    } eqc_state_e;

    typedef logic [7:0] eqc_byte_t;
    typedef logic [2:0] eqc_step_t;
    typedef logic [3:0][2:0] eqc_gains_t;

endpackage

`default_nettype wire

//--- pkg/eqc_regs.svh
// Constants of the equalizer control slave: address, fields, reset values
`ifndef EQC_REGS_SVH
`define EQC_REGS_SVH

// Fixed upper six bits of the chip address and the write direction bit
`define EQC_ADDR_HI     6'h21
`define EQC_ADDR_WR     1'h0

// Bit counter value of the last bit of a byte
`define EQC_BIT_LAST    3'h7
`define EQC_BIT_FIRST   3'h0

// Data byte field positions
`define EQC_CMD_BIT     7
`define EQC_BAND_HI     6
`define EQC_BAND_LO     4
`define EQC_DIR_BIT     3
`define EQC_CRS_HI      5
`define EQC_CRS_LO      3
`define EQC_LOW_HI      2
`define EQC_LOW_LO      0

// Command kinds carried in the top bit
`define EQC_CMD_VOLUME  1'h0
`define EQC_CMD_BAND    1'h1

// Band select codes
`define EQC_BAND_1      3'h1
`define EQC_BAND_2      3'h2
`define EQC_BAND_3      3'h3
`define EQC_BAND_4      3'h4

// Reset state: volume -17.25 dB (15 + 2.25), bands cut by 12 dB
`define EQC_FINE_RST    3'h6
`define EQC_COARSE_RST  3'h5
`define EQC_GAIN_RST    3'h6
`define EQC_CUT_RST     1'h1

// Idle level of the bus lines and of the open strap
`define EQC_LINE_IDLE   3'h7

`endif

//--- src/eqc_cmd_decode.sv
// Data byte decoder holding the volume and band settings
`default_nettype none
`include "eqc_regs.svh"

module eqc_cmd_decode
    import eqc_pkg::*;
(
    input  wire logic       sys_clk_i,    // System clock
    input  wire logic       sys_rst_i,    // Synchronous reset, high
    input  wire logic       byte_valid_i, // One-cycle data byte strobe
    input  wire eqc_byte_t  byte_i,       // Received data byte
    output eqc_step_t       fine_attenuation_o,   // 0.375 dB steps
    output eqc_step_t       coarse_attenuation_o, // 3 dB steps
    output logic      [3:0] cut_boost_select_o,   // Per band, 1 = cut
    output eqc_gains_t      band_gain_o           // Per band, 2 dB steps
);

    // One-hot band enable from a band select code, zero when unused
    function automatic logic [3:0] band_hot(input logic [2:0] sel);
        logic [3:0] hot;
        hot = 4'h0;
        unique case (sel)
            `EQC_BAND_1: hot = 4'h1;
            `EQC_BAND_2: hot = 4'h2;
            `EQC_BAND_3: hot = 4'h4;
            `EQC_BAND_4: hot = 4'h8;
            default:     hot = 4'h0;
        endcase
        return hot;
    endfunction

    logic       is_vol;
    logic [3:0] band_en;

    // Command kind and band selection of the current byte
    assign is_vol  = byte_i[`EQC_CMD_BIT] == `EQC_CMD_VOLUME;
    assign band_en = byte_valid_i && !is_vol ?
                     band_hot(byte_i[`EQC_BAND_HI:`EQC_BAND_LO]) : 4'h0;

    // Volume stage settings; bit 6 is ignored
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fine_attenuation_o   <= `EQC_FINE_RST;
            coarse_attenuation_o <= `EQC_COARSE_RST;
        end else if (byte_valid_i && is_vol) begin
            fine_attenuation_o   <= byte_i[`EQC_LOW_HI:`EQC_LOW_LO];
            coarse_attenuation_o <= byte_i[`EQC_CRS_HI:`EQC_CRS_LO];
        end
    end

    // Band settings; unused band codes change nothing
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cut_boost_select_o <= {4{`EQC_CUT_RST}};
            band_gain_o        <= {4{`EQC_GAIN_RST}};
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (band_en[b]) begin
                    cut_boost_select_o[b] <= byte_i[`EQC_DIR_BIT];
                    band_gain_o[b] <= byte_i[`EQC_LOW_HI:`EQC_LOW_LO];
                end
            end
        end
    end

    // Volume byte loads both attenuation fields
    AST_VOL_LOAD: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        byte_valid_i && !byte_i[7] |=>
            fine_attenuation_o == $past(byte_i[2:0]) &&
            coarse_attenuation_o == $past(byte_i[5:3]) &&
            $stable(band_gain_o))
        else $error("volume byte not loaded");

    // Unused band codes leave the band settings and the fine attenuation alone
    AST_BAD_BAND_KEEPS: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        byte_valid_i && byte_i[7] &&
        (byte_i[6:4] == 3'h0 || byte_i[6:4] > 3'h4) |=>
            $stable(band_gain_o) && $stable(cut_boost_select_o) &&
            $stable(fine_attenuation_o))
        else $error("unused band code changed a setting");

    // Band four byte sets gain and direction of band four
    AST_BAND4_LOAD: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        byte_valid_i && byte_i[7:4] == 4'hc |=>
            band_gain_o[3] == $past(byte_i[2:0]) &&
            cut_boost_select_o[3] == $past(byte_i[3]) &&
            $stable(band_gain_o[0]))
        else $error("band four not loaded");

    // Settings after reset
    AST_RESET_STATE: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |->
            fine_attenuation_o == 3'h6 && coarse_attenuation_o == 3'h5 &&
            band_gain_o == {4{3'h6}} && cut_boost_select_o == 4'hf)
        else $error("wrong settings after reset");

endmodule

`default_nettype wire

//--- src/eqc_i2c_slave.sv
// Write-only two-wire control slave of the four band equalizer
`default_nettype none
`include "eqc_regs.svh"

// Contract
// - SDA stable while SCL high; sample then
// - SDA falling with SCL high starts transfer
// - SDA rising with SCL high ends transfer
// - Eight bits per byte, MSB first, ack
// - Slave holds SDA low through ack pulse
// - Addressed slave acknowledges every received byte
// - Start, address, data bytes, then stop
// - Accept only address 0x84 or 0x86
// - Variable address bit follows strap pin
// - MSB 0: volume, low bits fine attenuation
// - Volume spans 0 to -23.625 dB
// - MSB 1: band command, bits 6..4 band
// - Bit 3 set means cut, clear boost
// - Low bits band magnitude, 2 dB steps
// - Reset: volume -17.25 dB, bands -12 dB
module eqc_i2c_slave
    import eqc_pkg::*;
(
    input  wire logic  sys_clk_i,    // System clock, 250 MHz
    input  wire logic  sys_rst_i,    // Synchronous reset, high
    input  wire logic  scl_i,        // Bus clock pin
    input  wire logic  sda_i,        // Bus data pin, input side
    output logic       sda_o,        // Bus data pin, output value
    output logic       sda_oe_o,     // Bus data pin, drive enable
    input  wire logic  addr_strap_i, // Address strap, high when open
    output logic       busy_o,       // Addressed transfer in progress
    output eqc_step_t  fine_attenuation_o,   // Volume, 0.375 dB steps
    output eqc_step_t  coarse_attenuation_o, // Volume, 3 dB steps
    output logic [3:0] cut_boost_select_o,   // Per band, 1 = cut
    output eqc_gains_t band_gain_o           // Per band, 2 dB steps
);

    // Synchronised pins and their previous samples
    logic [2:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       strap_s;
    logic       scl_q;
    logic       sda_q;

    // Bus events found by the system clock
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    // Receive state
    eqc_state_e state_q;
    logic [2:0] bit_cnt_q;
    eqc_byte_t  shift_q;
    eqc_byte_t  rx_byte;
    eqc_byte_t  own_addr;
    logic       last_bit;
    logic       in_ack;
    logic       sda_oe_q;
    logic       byte_valid_q;
    eqc_byte_t  data_q;

    // The bus is slow against the system clock, so two stages suffice
    eqc_sync2 u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({addr_strap_i, sda_i, scl_i}),
        .sync_o    (pins_s)
    );

    assign scl_s   = pins_s[0];
    assign sda_s   = pins_s[1];
    assign strap_s = pins_s[2];

    // Previous samples for edge finding
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Edges of the clock line; data is taken on the rising edge
    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;

    // Data line edges while the clock stays high are frame markers
    assign start_det = scl_s && scl_q && sda_q && !sda_s;
    assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

    // Own address: fixed bits, strap bit, write direction
    assign own_addr = {`EQC_ADDR_HI, strap_s, `EQC_ADDR_WR};

    // Byte as it stands once the current bit is shifted in, MSB first
    assign rx_byte  = {shift_q[6:0], sda_s};
    assign last_bit = bit_cnt_q == `EQC_BIT_LAST;
    assign in_ack   = state_q == st_addr_ack || state_q == st_data_ack;

    // Transfer sequence: start, address, data bytes, stop
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q <= st_idle;
        end else if (stop_det) begin
            state_q <= st_idle;
        end else if (start_det) begin
            state_q <= st_addr;
        end else if (scl_rise && last_bit) begin
            unique case (state_q)
                st_addr: begin
                    if (rx_byte == own_addr) begin
                        state_q <= st_addr_ack;
                    end else begin
                        state_q <= st_ignore;
                    end
                end
                st_data: begin
                    state_q <= st_data_ack;
                end
                st_idle, st_addr_ack, st_data_ack, st_ignore: begin
                    state_q <= state_q;
                end
            endcase
        end else if (scl_fall && in_ack && sda_oe_q) begin
            state_q <= st_data;
        end
    end

    // Bit counter and shift register run on rising clock edges
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bit_cnt_q <= `EQC_BIT_FIRST;
            shift_q   <= 8'h00;
        end else if (start_det || stop_det) begin
            bit_cnt_q <= `EQC_BIT_FIRST;
        end else if (scl_rise &&
                     (state_q == st_addr || state_q == st_data)) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= rx_byte;
        end
    end

    // Acknowledge drive: on after the eighth pulse falls, off after ninth
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sda_oe_q <= 1'h0;
        end else if (stop_det || start_det) begin
            sda_oe_q <= 1'h0;
        end else if (scl_fall && in_ack) begin
            sda_oe_q <= !sda_oe_q;
        end
    end

    // Every byte of an addressed transfer is acknowledged whether or not the master looks
    assign sda_oe_o = sda_oe_q;
    assign sda_o    = 1'h0;

    // Completed data byte is handed to the decoder for one cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            byte_valid_q <= 1'h0;
            data_q       <= 8'h00;
        end else begin
            byte_valid_q <= scl_rise && last_bit && state_q == st_data;
            if (scl_rise && last_bit && state_q == st_data) begin
                data_q <= rx_byte;
            end
        end
    end

    // Addressed flag for the outside world
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'h0;
        end else begin
            busy_o <= state_q == st_addr_ack || state_q == st_data ||
                      state_q == st_data_ack;
        end
    end

    // Volume precedes the bands; the decoder holds both settings
    eqc_cmd_decode u_decode (
        .sys_clk_i            (sys_clk_i),
        .sys_rst_i            (sys_rst_i),
        .byte_valid_i         (byte_valid_q),
        .byte_i               (data_q),
        .fine_attenuation_o   (fine_attenuation_o),
        .coarse_attenuation_o (coarse_attenuation_o),
        .cut_boost_select_o   (cut_boost_select_o),
        .band_gain_o          (band_gain_o)
    );

    // Start always leads to address reception
    AST_START_TO_ADDR: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        start_det && !stop_det |=> state_q == st_addr &&
                                    bit_cnt_q == 3'h0 && !sda_oe_o)
        else $error("start not followed by address phase");

    // Stop releases the line and ends the transfer
    AST_STOP_TO_IDLE: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        stop_det |=> state_q == st_idle && !sda_oe_o ##1 !busy_o)
        else $error("stop did not end transfer");

    // Acknowledge is held across the whole ninth clock high phase
    AST_ACK_HELD: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        in_ack && sda_oe_o && scl_s && !start_det && !stop_det |=>
            sda_oe_o)
        else $error("acknowledge released while clock high");

    // Drive enable only rises just after a clock fall
    AST_OE_ON_FALL: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(sda_oe_o) |-> $past(scl_fall) && $past(scl_q))
        else $error("data line changed outside clock low");

    // Eighth bit of a matching address leads to an acknowledge state
    AST_ADDR_MATCH: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_addr && scl_rise && last_bit &&
        !start_det && !stop_det |=>
            state_q == ($past(rx_byte) == {6'h21, $past(strap_s), 1'h0} ?
                        st_addr_ack : st_ignore))
        else $error("address decision wrong");

    // Data byte strobe follows exactly the eighth bit of a data byte
    AST_BYTE_STROBE: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        byte_valid_q |-> $past(bit_cnt_q) == 3'h7 &&
                         $past(state_q) == st_data &&
                         state_q == st_data_ack)
        else $error("byte strobe not on eighth bit");

    // Ignored transfers never drive the line
    AST_IGNORE_SILENT: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        sda_oe_o |-> in_ack)
        else $error("line driven outside acknowledge slot");

    // After a data byte the drive comes on at the next clock fall
    AST_ACK_STARTS: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_data_ack && scl_fall && !sda_oe_o &&
        !start_det && !stop_det |=> sda_oe_o && state_q == st_data_ack)
        else $error("acknowledge not given");

    // A matching address is acknowledged at the next clock fall
    AST_ADDR_ACKS: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_addr_ack && scl_fall && !sda_oe_o &&
        !start_det && !stop_det |=> sda_oe_o && state_q == st_addr_ack)
        else $error("address not acknowledged");

    // Falling edge of the ninth pulse releases the line, data follows
    AST_ACK_ENDS: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        in_ack && sda_oe_o && scl_fall && !start_det && !stop_det |=>
            !sda_oe_o && state_q == st_data)
        else $error("acknowledge not released after ninth pulse");

    // Each rising clock edge of a byte counts and shifts one bit
    AST_BIT_SHIFT: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        scl_rise && (state_q == st_addr || state_q == st_data) &&
        !start_det && !stop_det |=>
            bit_cnt_q == $past(bit_cnt_q) + 3'h1 &&
            shift_q[0] == $past(sda_s))
        else $error("bit not counted or shifted");

    // A foreign address stays ignored until the next frame marker
    AST_IGNORE_QUIET: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_ignore && !start_det && !stop_det |=>
            state_q == st_ignore && !sda_oe_o)
        else $error("ignored transfer left its state");

    // Busy flag is low when no addressed transfer is running
    AST_BUSY_FLAG: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_idle || state_q == st_ignore ||
        state_q == st_addr |=> !busy_o)
        else $error("busy set without an addressed transfer");

    // The decoder receives exactly the byte assembled on the eighth bit
    AST_STROBE_DATA: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        byte_valid_q |-> data_q == $past(rx_byte))
        else $error("wrong byte handed to decoder");

    // An idle slave neither drives the line nor hands over bytes
    AST_IDLE_QUIET: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        state_q == st_idle |-> !sda_oe_o && !byte_valid_q)
        else $error("idle slave active");

endmodule

`default_nettype wire

//--- src/eqc_sync2.sv
// Two-stage synchroniser for the bus pins and the address strap
`default_nettype none
`include "eqc_regs.svh"

module eqc_sync2
    import eqc_pkg::*;
(
    input  wire logic       sys_clk_i, // System clock
    input  wire logic       sys_rst_i, // Synchronous reset, high
    input  wire logic [2:0] async_i,   // Pins from outside the domain
    output logic      [2:0] sync_o     // Synchronised levels
);

    logic [2:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= `EQC_LINE_IDLE;
            sync_o <= `EQC_LINE_IDLE;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire
